// ==== logic/can_status_and_message_objects.sv ====
// CAN controller status register, message objects, filtering and transmit scheduling
//
// Functional notes
// - Software sets auto retransmit; failed sends retry only when set; readable.
// - Reading main status clears the pending status interrupt.
// - Status shows bus-off while the controller is bus-off.
// - Error warning set when transmit or receive error count reaches 96.
// - Status shows the error-passive state.
// - Receive success set for every good frame, whatever the filters say.
// - Transmit success set for every frame sent successfully.
// - Three-bit last error code holds the latest bus error kind.
// - Read-only bitmap shows objects with a transmit request pending.
// - Bitmap shows objects holding new data not yet read.
// - Bitmap shows objects with a valid configuration.
// - Thirty-two objects, chosen by index, not by CAN identifier.
// - Remote request sender sends no data, then receives the answer.
// - Remote request receiver takes matching remote frames and interrupts.
// - Auto responder answers a matching remote frame with stored data.
// - Filter on: incoming id ANDed with mask must equal id.
// - Per-object enables interrupt on transmit done and on receive.
// - Optional direction filter and extended-only filter per object.
// - Chained objects fill in ascending order; last one lacks the chain flag.
// - Object read reports new data and overwritten data.
// - Object read reports a received remote request.
`timescale 1ns/1ps
`default_nettype none
`include "can_status_regs.svh"

module can_status_and_message_objects (
    // Clock and reset
    input  wire logic                  i_core_clk,
    input  wire logic                  i_rst_n,
    // Register port
    input  wire logic [7:0]            i_addr,
    input  wire logic [31:0]           i_wdata,
    input  wire logic                  i_wr,
    input  wire logic                  i_rd,
    output logic      [31:0]           o_rdata,
    // Receive side of the protocol engine
    input  wire logic                  i_rx_valid,
    input  wire can_status_pkg::frame_t i_rx_frame,
    // Transmit side of the protocol engine
    output logic                       o_tx_valid,
    output can_status_pkg::frame_t     o_tx_frame,
    input  wire logic                  i_tx_done,
    input  wire logic                  i_tx_error,
    // Error state of the protocol engine
    input  wire logic                  i_err_valid,
    input  wire logic [2:0]            i_err_code,
    input  wire logic [7:0]            i_tec,
    input  wire logic [7:0]            i_rec,
    input  wire logic                  i_err_passive,
    input  wire logic                  i_bus_off,
    // Status outputs
    output logic                       o_auto_retransmit,
    output logic                       o_irq
);
    import can_status_pkg::*;

    state_t      q;
    state_t      d;
    logic        sev;
    logic [31:0] txp_map;
    logic [31:0] nd_map;
    logic [31:0] mv_map;
    logic [31:0] ip_map;
    logic [31:0] hit;

    // ------------------------------------------------------------
    // Per-object bitmaps and acceptance
    // ------------------------------------------------------------
    for (genvar g = 0; g < 32; g++) begin : g_obj
        obj_t o;
        logic want_rtr;
        logic dir_ok;
        logic ext_ok;
        logic id_ok;
        assign o = q.obj[g];
        assign txp_map[g] = o.valid & o.txrq;
        assign nd_map[g] = o.newd;
        assign mv_map[g] = o.valid;
        assign ip_map[g] = o.ipnd;
        assign want_rtr = (o.typ == object_type_remote_request_receiver) ||
                          (o.typ == object_type_remote_auto_responder);
        assign dir_ok = (o.dirf | want_rtr) ? (i_rx_frame.rtr == want_rtr) : 1'b1;
        assign ext_ok = o.extf ? i_rx_frame.ext : 1'b1;
        assign id_ok = o.idf ? ((i_rx_frame.id & o.mask) == o.id) : (i_rx_frame.id == o.id);
        // Full chained entries are skipped
        assign hit[g] = o.valid & (o.typ != object_type_transmit) & dir_ok & ext_ok &
                        id_ok & ~(o.chain & o.newd);
    end

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb begin
        logic [4:0] idx;
        logic [4:0] tgt;
        logic       found;
        logic [4:0] nxt;
        logic       any;
        d = q;
        idx = i_wdata[4:0];
        tgt = 5'h00;
        found = 1'b0;
        nxt = 5'h00;
        any = 1'b0;
        sev = 1'b0;
        d.rdata = 32'h0000_0000;
        // Controller state from the engine
        d.ewarn = (i_tec >= `CS_EWARN_LIM) || (i_rec >= `CS_EWARN_LIM);
        d.epass = i_err_passive;
        d.boff = i_bus_off;
        if ((d.ewarn != q.ewarn) || (d.boff != q.boff) || (d.epass != q.epass)) begin
            sev = 1'b1;
        end
        // Register reads
        if (i_rd) begin
            case (i_addr)
                `CS_OFS_CTRL: d.rdata = {31'h0, q.retry};
                `CS_OFS_STAT: begin
                    d.rdata = {24'h0, q.boff, q.ewarn, q.epass, q.rxok, q.txok, q.lec};
                    d.sirq = 1'b0;
                end
                `CS_OFS_TXP: d.rdata = txp_map;
                `CS_OFS_NEWD: d.rdata = nd_map;
                `CS_OFS_VALID: d.rdata = mv_map;
                `CS_OFS_IPND: d.rdata = ip_map;
                `CS_OFS_ID: d.rdata = {3'h0, q.stg.id};
                `CS_OFS_MASK: d.rdata = {3'h0, q.stg.mask};
                `CS_OFS_CFG: d.rdata = {18'h0, q.stg.dlc, q.stg.chain, q.stg.rxie,
                                       q.stg.txie, q.stg.ext, q.stg.extf, q.stg.dirf,
                                       q.stg.idf, q.stg.typ};
                `CS_OFS_DLO: d.rdata = q.stg.data[31:0];
                `CS_OFS_DHI: d.rdata = q.stg.data[63:32];
                `CS_OFS_FLAGS: d.rdata = {29'h0, q.stg.rmt, q.stg.lost, q.stg.newd};
                default: d.rdata = 32'h0000_0000;
            endcase
        end
        // Register writes
        if (i_wr) begin
            case (i_addr)
                `CS_OFS_CTRL: d.retry = i_wdata[0];
                `CS_OFS_STAT: begin
                    if (i_wdata[`CS_STAT_TXOK]) begin
                        d.txok = 1'b0;
                    end
                    if (i_wdata[`CS_STAT_RXOK]) begin
                        d.rxok = 1'b0;
                    end
                end
                `CS_OFS_ID: d.stg.id = i_wdata[28:0];
                `CS_OFS_MASK: d.stg.mask = i_wdata[28:0];
                `CS_OFS_CFG: begin
                    d.stg.typ = obj_type_t'(i_wdata[2:0]);
                    d.stg.idf = i_wdata[`CS_CFG_IDF];
                    d.stg.dirf = i_wdata[`CS_CFG_DIRF];
                    d.stg.extf = i_wdata[`CS_CFG_EXTF];
                    d.stg.ext = i_wdata[`CS_CFG_EXT];
                    d.stg.txie = i_wdata[`CS_CFG_TXIE];
                    d.stg.rxie = i_wdata[`CS_CFG_RXIE];
                    d.stg.chain = i_wdata[`CS_CFG_CHAIN];
                    d.stg.dlc = i_wdata[`CS_CFG_DLC +: 4];
                end
                `CS_OFS_DLO: d.stg.data[31:0] = i_wdata;
                `CS_OFS_DHI: d.stg.data[63:32] = i_wdata;
                `CS_OFS_CMD: begin
                    // Object chosen by index
                    if (i_wdata[`CS_CMD_FREE]) begin
                        d.obj[idx].valid = 1'b0;
                        d.obj[idx].txrq = 1'b0;
                        d.obj[idx].ipnd = 1'b0;
                    end else if (i_wdata[`CS_CMD_WRITE]) begin
                        d.obj[idx] = q.stg;
                        // Wide identifiers forced to long format
                        d.obj[idx].ext = q.stg.ext | (|q.stg.id[28:11]);
                        d.obj[idx].valid = 1'b1;
                        d.obj[idx].txrq = i_wdata[`CS_CMD_TXREQ];
                        d.obj[idx].newd = 1'b0;
                        d.obj[idx].lost = 1'b0;
                        d.obj[idx].rmt = 1'b0;
                        d.obj[idx].ipnd = 1'b0;
                    end else begin
                        d.stg = q.obj[idx];
                        d.obj[idx].newd = 1'b0;
                        d.obj[idx].lost = 1'b0;
                        d.obj[idx].rmt = 1'b0;
                        if (i_wdata[`CS_CMD_CLRINT]) begin
                            d.obj[idx].ipnd = 1'b0;
                        end
                    end
                end
                default: begin
                end
            endcase
        end
        // Bus error code
        if (i_err_valid) begin
            d.lec = err_code_t'(i_err_code);
            sev = 1'b1;
        end
        // Frame received from the bus; set wins over host clears
        if (i_rx_valid) begin
            d.rxok = 1'b1;
            sev = 1'b1;
            for (int i = 31; i >= 0; i--) begin
                if (hit[i]) begin
                    tgt = i[4:0];
                    found = 1'b1;
                end
            end
            if (found) begin
                d.obj[tgt].newd = 1'b1;
                d.obj[tgt].lost = q.obj[tgt].lost | q.obj[tgt].newd;
                if (i_rx_frame.rtr) begin
                    d.obj[tgt].rmt = 1'b1;
                    if (q.obj[tgt].typ == object_type_remote_auto_responder) begin
                        d.obj[tgt].txrq = 1'b1;
                    end else begin
                        d.obj[tgt].ipnd = 1'b1;
                    end
                end else begin
                    d.obj[tgt].data = i_rx_frame.data;
                    d.obj[tgt].dlc = i_rx_frame.dlc;
                    if (q.obj[tgt].rxie) begin
                        d.obj[tgt].ipnd = 1'b1;
                    end
                end
            end
        end
        // Transmit scheduling, lowest index first
        if (q.busy) begin
            if (i_tx_done) begin
                d.busy = 1'b0;
                d.txok = 1'b1;
                sev = 1'b1;
                d.obj[q.tx_idx].txrq = 1'b0;
                if (q.obj[q.tx_idx].txie) begin
                    d.obj[q.tx_idx].ipnd = 1'b1;
                end
            end else if (i_tx_error) begin
                d.busy = 1'b0;
                if (!q.retry) begin
                    d.obj[q.tx_idx].txrq = 1'b0;
                end
            end
        end else begin
            for (int i = 31; i >= 0; i--) begin
                if (txp_map[i]) begin
                    nxt = i[4:0];
                    any = 1'b1;
                end
            end
            if (any) begin
                d.busy = 1'b1;
                d.tx_idx = nxt;
                d.tx.id = q.obj[nxt].id;
                d.tx.ext = q.obj[nxt].ext;
                // Remote request carries no data
                d.tx.rtr = (q.obj[nxt].typ == object_type_remote_request_sender);
                d.tx.dlc = q.obj[nxt].dlc;
                d.tx.data = q.obj[nxt].data;
            end
        end
        if (sev) begin
            d.sirq = 1'b1;
        end
        d.irq = d.sirq | (|ip_map);
    end

    // ------------------------------------------------------------
    // State register
    // ------------------------------------------------------------
    always_ff @(posedge i_core_clk) begin
        if (!i_rst_n) begin
            q <= '0;
            q.retry <= `CS_RST_RETRY;
        end else begin
            q <= d;
        end
    end

    assign o_rdata = q.rdata;
    assign o_tx_valid = q.busy;
    assign o_tx_frame = q.tx;
    assign o_auto_retransmit = q.retry;
    assign o_irq = q.irq;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking cb @(posedge i_core_clk); endclocking
    default disable iff (!i_rst_n);

    sequence s_tx_ok;
        o_tx_valid && i_tx_done;
    endsequence

    sequence s_tx_fail;
        o_tx_valid && !i_tx_done && i_tx_error && !o_auto_retransmit && !i_wr;
    endsequence

    a_retry_readback: assert property (
        (i_wr && i_addr == `CS_OFS_CTRL) |=> (o_auto_retransmit == $past(i_wdata[0]))
        ##1 (!$past(i_rd) || $past(i_addr) != `CS_OFS_CTRL || o_rdata[0] == o_auto_retransmit))
        else $error("retransmit setting not stored");

    a_stat_read_clr: assert property (
        (i_rd && i_addr == `CS_OFS_STAT && !sev) |=> !q.sirq)
        else $error("status read left interrupt pending");

    a_busoff_flag: assert property (
        $rose(i_bus_off) |=> q.boff && q.sirq)
        else $error("bus-off not flagged");

    a_ewarn_level: assert property (
        1'b1 |=> (q.ewarn == (($past(i_tec) >= `CS_EWARN_LIM) || ($past(i_rec) >= `CS_EWARN_LIM))))
        else $error("error warning wrong");

    a_epass_flag: assert property (
        i_err_passive [*2] |-> q.epass)
        else $error("error passive not shown");

    a_rx_ok_set: assert property (
        i_rx_valid |=> q.rxok && q.sirq)
        else $error("receive success not set");

    a_tx_ok_set: assert property (
        s_tx_ok |=> q.txok && !o_tx_valid)
        else $error("transmit success not set");

    a_lec_load: assert property (
        i_err_valid |=> (q.lec == $past(i_err_code)))
        else $error("last error code not loaded");

    a_txp_bitmap: assert property (
        (i_rd && i_addr == `CS_OFS_TXP) |=> (o_rdata == $past(txp_map)))
        else $error("pending bitmap read wrong");

    a_no_retry_drop: assert property (
        s_tx_fail |=> !txp_map[$past(q.tx_idx)])
        else $error("failed send retried while retry off");

    a_newd_bitmap: assert property (
        (i_rd && i_addr == `CS_OFS_NEWD) |=> (o_rdata == $past(nd_map)))
        else $error("new data bitmap read wrong");

    a_valid_bitmap: assert property (
        (i_rd && i_addr == `CS_OFS_VALID) |=> (o_rdata == $past(mv_map)))
        else $error("valid bitmap read wrong");

    a_stat_fields: assert property (
        (i_rd && i_addr == `CS_OFS_STAT) |=> (o_rdata[7:5] == $past({q.boff, q.ewarn, q.epass})))
        else $error("status fields read wrong");

    a_irq_level: assert property (
        1'b1 |=> (o_irq == (q.sirq || $past(|ip_map))))
        else $error("interrupt output wrong");

    a_tx_frame_hold: assert property (
        (o_tx_valid && !i_tx_done && !i_tx_error) |=> (o_tx_valid && $stable(o_tx_frame)))
        else $error("offered frame dropped or changed");

    a_flags_read: assert property (
        (i_rd && i_addr == `CS_OFS_FLAGS) |=> (o_rdata[2:0] == $past({q.stg.rmt, q.stg.lost, q.stg.newd})))
        else $error("object flags read wrong");
endmodule // can_status_and_message_objects
`default_nettype wire

// ==== logic/can_status_regs.svh ====
// Register offsets, field positions, reset values and limits of the CAN status block
`ifndef CAN_STATUS_REGS_SVH
`define CAN_STATUS_REGS_SVH
// ------------------------------------------------------------
// Register offsets
// ------------------------------------------------------------
`define CS_OFS_CTRL  8'h00
`define CS_OFS_STAT  8'h04
`define CS_OFS_TXP   8'h08
`define CS_OFS_NEWD  8'h0c
`define CS_OFS_VALID 8'h10
`define CS_OFS_IPND  8'h14
`define CS_OFS_ID    8'h20
`define CS_OFS_MASK  8'h24
`define CS_OFS_CFG   8'h28
`define CS_OFS_DLO   8'h2c
`define CS_OFS_DHI   8'h30
`define CS_OFS_CMD   8'h34
`define CS_OFS_FLAGS 8'h38
// ------------------------------------------------------------
// Field positions
// ------------------------------------------------------------
`define CS_STAT_TXOK  3
`define CS_STAT_RXOK  4
`define CS_CFG_IDF    3
`define CS_CFG_DIRF   4
`define CS_CFG_EXTF   5
`define CS_CFG_EXT    6
`define CS_CFG_TXIE   7
`define CS_CFG_RXIE   8
`define CS_CFG_CHAIN  9
`define CS_CFG_DLC    10
`define CS_CMD_WRITE  8
`define CS_CMD_TXREQ  9
`define CS_CMD_CLRINT 10
`define CS_CMD_FREE   11
// ------------------------------------------------------------
// Reset values and limits
// ------------------------------------------------------------
`define CS_RST_RETRY  1'b1
`define CS_EWARN_LIM  8'h60
`endif

// ==== logic/can_status_pkg.sv ====
// Types shared by the CAN status and message object block
package can_status_pkg;
    typedef enum logic [2:0] {
        object_type_transmit,
        object_type_receive,
        object_type_remote_request_sender,
        object_type_remote_request_receiver,
        object_type_remote_auto_responder
    } obj_type_t;

    typedef enum logic [2:0] {
        error_code_none,
        error_code_stuffing,
        error_code_format,
        error_code_no_acknowledge,
        error_code_recessive_bit,
        error_code_dominant_bit,
        error_code_checksum
    } err_code_t;

    typedef struct packed {
        logic [28:0] id;
        logic        ext;
        logic        rtr;
        logic [3:0]  dlc;
        logic [63:0] data;
    } frame_t;

    typedef struct packed {
        logic        valid;
        logic        txrq;
        logic        newd;
        logic        lost;
        logic        rmt;
        logic        ipnd;
        obj_type_t   typ;
        logic        idf;
        logic        dirf;
        logic        extf;
        logic        ext;
        logic        txie;
        logic        rxie;
        logic        chain;
        logic [3:0]  dlc;
        logic [28:0] id;
        logic [28:0] mask;
        logic [63:0] data;
    } obj_t;

    typedef struct packed {
        obj_t [31:0] obj;
        obj_t        stg;
        logic        retry;
        err_code_t   lec;
        logic        txok;
        logic        rxok;
        logic        epass;
        logic        ewarn;
        logic        boff;
        logic        sirq;
        logic        busy;
        logic [4:0]  tx_idx;
        frame_t      tx;
        logic [31:0] rdata;
        logic        irq;
    } state_t;
endpackage

// ==== tb/can_engine_model.sv ====
// Protocol engine stand-in on the bus side of the message object block
`timescale 1ns/1ps
`default_nettype none

module can_engine_model (
    // Clock and reset
    input  wire logic                   i_core_clk,
    input  wire logic                   i_rst_n,
    // Transmit offer from the block
    input  wire logic                   i_tx_valid,
    input  wire can_status_pkg::frame_t i_tx_frame,
    output logic                        o_tx_done = 1'b0,
    output logic                        o_tx_error = 1'b0,
    // Frames seen on the bus
    output logic                        o_rx_valid = 1'b0,
    output can_status_pkg::frame_t      o_rx_frame = '1
);
    import can_status_pkg::*;
    int     fail_cnt = 0;
    int     slow     = 0;
    int     sent_cnt = 0;
    int     wait_q   = 0;
    frame_t last_tx;

    // Answer an offer after slow cycles; fail while fail_cnt is above zero
    always @(posedge i_core_clk) begin
        o_tx_done  <= 1'b0;
        o_tx_error <= 1'b0;
        if (!i_rst_n) begin
            wait_q <= 0;
        end else if (i_tx_valid && !o_tx_done && !o_tx_error) begin
            if (wait_q < slow) begin
                wait_q <= wait_q + 1;
            end else begin
                wait_q  <= 0;
                last_tx <= i_tx_frame;
                if (fail_cnt > 0) begin
                    o_tx_error <= 1'b1;
                    fail_cnt   <= fail_cnt - 1;
                end else begin
                    o_tx_done <= 1'b1;
                    sent_cnt  <= sent_cnt + 1;
                end
            end
        end
    end

    // One good frame from another node; lines scrambled afterwards
    task automatic send(input frame_t f);
        @(posedge i_core_clk);
        o_rx_valid <= 1'b1;
        o_rx_frame <= f;
        @(posedge i_core_clk);
        o_rx_valid <= 1'b0;
        o_rx_frame <= ~f;
    endtask
endmodule // can_engine_model

`default_nettype wire

// ==== tb/tb_top.sv ====
// Self-checking bench for the CAN status and message object block
`timescale 1ns/1ps
`default_nettype none
`include "can_status_regs.svh"

module tb_top;
    import can_status_pkg::*;
    typedef struct packed {
        logic [7:0] tec;
        logic [7:0] rec;
        logic       ep;
        logic       bo;
        logic [2:0] st;
    } row_t;
    logic        i_core_clk    = 1'b0;
    logic        i_rst_n       = 1'b0;
    logic [7:0]  i_addr        = 8'h00;
    logic [31:0] i_wdata       = 32'h0;
    logic        i_wr          = 1'b0;
    logic        i_rd          = 1'b0;
    logic        i_err_valid   = 1'b0;
    logic [2:0]  i_err_code    = 3'h0;
    logic [7:0]  i_tec         = 8'h00;
    logic [7:0]  i_rec         = 8'h00;
    logic        i_err_passive = 1'b0;
    logic        i_bus_off     = 1'b0;
    logic [31:0] o_rdata;
    logic        rx_valid, tx_valid, tx_done, tx_error, o_auto_retransmit, o_irq;
    frame_t      rx_frame, tx_frame;
    int          error_cnt = 0;
    int          checks    = 0;
    int          n;
    row_t        rows [7] = '{'{8'd95, 8'd95, 1'b0, 1'b0, 3'b000}, '{8'd96, 8'd0, 1'b0, 1'b0, 3'b010},
                              '{8'd0, 8'd96, 1'b0, 1'b0, 3'b010}, '{8'd0, 8'd0, 1'b1, 1'b0, 3'b001},
                              '{8'd128, 8'd0, 1'b1, 1'b0, 3'b011}, '{8'd255, 8'd0, 1'b0, 1'b1, 3'b110},
                              '{8'd0, 8'd0, 1'b0, 1'b0, 3'b000}};

    always #5 i_core_clk = ~i_core_clk;

    can_status_and_message_objects dut_u (
        .i_core_clk (i_core_clk), .i_rst_n (i_rst_n), .i_addr (i_addr), .i_wdata (i_wdata),
        .i_wr (i_wr), .i_rd (i_rd), .o_rdata (o_rdata), .i_rx_valid (rx_valid),
        .i_rx_frame (rx_frame), .o_tx_valid (tx_valid), .o_tx_frame (tx_frame),
        .i_tx_done (tx_done), .i_tx_error (tx_error), .i_err_valid (i_err_valid),
        .i_err_code (i_err_code), .i_tec (i_tec), .i_rec (i_rec), .i_err_passive (i_err_passive),
        .i_bus_off (i_bus_off), .o_auto_retransmit (o_auto_retransmit), .o_irq (o_irq));

    can_engine_model eng_u (
        .i_core_clk (i_core_clk), .i_rst_n (i_rst_n), .i_tx_valid (tx_valid), .i_tx_frame (tx_frame),
        .o_tx_done (tx_done), .o_tx_error (tx_error), .o_rx_valid (rx_valid), .o_rx_frame (rx_frame));

    // ----------------------------------------
    // Shared tasks
    // ----------------------------------------
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge i_core_clk);
        i_wr    <= 1'b1;
        i_addr  <= a;
        i_wdata <= d;
        @(posedge i_core_clk);
        i_wr <= 1'b0;
    endtask

    task automatic rc(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
        @(posedge i_core_clk);
        i_rd   <= 1'b1;
        i_addr <= a;
        @(posedge i_core_clk);
        i_rd <= 1'b0;
        #1;
        chk(o_rdata & m, e);
    endtask

    task automatic setobj(input logic [4:0] idx, input logic [28:0] id, input logic [28:0] mask,
                          input logic [13:0] cfg, input logic [31:0] dlo, input logic txrq);
        wr(`CS_OFS_ID, {3'h0, id});
        wr(`CS_OFS_MASK, {3'h0, mask});
        wr(`CS_OFS_CFG, {18'h0, cfg});
        wr(`CS_OFS_DLO, dlo);
        wr(`CS_OFS_CMD, {22'h0, txrq, 1'b1, 3'h0, idx});
    endtask

    task automatic sendf(input logic [28:0] id, input logic ext, input logic rtr, input logic [31:0] d);
        eng_u.send('{id: id, ext: ext, rtr: rtr, dlc: 4'h8, data: {~d, d}});
    endtask

    task automatic waitsent(input int base);
        for (int k = 0; k < 100; k++) begin
            if (eng_u.sent_cnt == base) @(posedge i_core_clk);
        end
        chk(32'(eng_u.sent_cnt), 32'(base + 1));
    endtask

    task automatic wrap_up;
        $display("checks %0d mismatches %0d", checks, error_cnt);
        if (error_cnt == 0 && checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    // ----------------------------------------
    // Watchdog
    // ----------------------------------------
    initial begin
        repeat (20000) @(posedge i_core_clk);
        error_cnt++;
        wrap_up();
    end

    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        repeat (16) @(posedge i_core_clk);
        i_rst_n <= 1'b1;
        @(posedge i_core_clk);
        #1;
        chk({31'h0, o_auto_retransmit}, 32'h1);
        chk({31'h0, o_irq}, 32'h0);
        rc(`CS_OFS_CTRL, 32'h1, 32'h1);
        rc(`CS_OFS_VALID, '1, 32'h0);
        $display("reset test done");
        foreach (rows[k]) begin
            @(posedge i_core_clk);
            i_tec         <= rows[k].tec;
            i_rec         <= rows[k].rec;
            i_err_passive <= rows[k].ep;
            i_bus_off     <= rows[k].bo;
            repeat (2) @(posedge i_core_clk);
            rc(`CS_OFS_STAT, 32'he0, {24'h0, rows[k].st, 5'h0});
        end
        for (int c = 0; c < 7; c++) begin
            @(posedge i_core_clk);
            i_err_valid <= 1'b1;
            i_err_code  <= 3'(c);
            @(posedge i_core_clk);
            i_err_valid <= 1'b0;
            rc(`CS_OFS_STAT, 32'h7, 32'(c));
        end
        wr(`CS_OFS_STAT, 32'h18);
        @(posedge i_core_clk);
        i_err_valid <= 1'b1;
        i_err_code  <= 3'h1;
        @(posedge i_core_clk);
        i_err_valid <= 1'b0;
        repeat (3) @(posedge i_core_clk);
        chk({31'h0, o_irq}, 32'h1);
        rc(`CS_OFS_STAT, 32'h7, 32'h1);
        repeat (3) @(posedge i_core_clk);
        chk({31'h0, o_irq}, 32'h0);
        $display("status test done");
        setobj(5'd0, 29'h400, 29'h7f8, 14'h2109, 32'h0, 1'b0);
        setobj(5'd2, 29'h123, '1, 14'h200c, 32'hcafe0123, 1'b0);
        setobj(5'd3, 29'h1a5, '1, 14'h2069, 32'h0, 1'b0);
        rc(`CS_OFS_VALID, '1, 32'hd);
        sendf(29'h403, 1'b0, 1'b0, 32'h11223344);
        rc(`CS_OFS_STAT, 32'h10, 32'h10);
        rc(`CS_OFS_NEWD, '1, 32'h1);
        chk({31'h0, o_irq}, 32'h1);
        wr(`CS_OFS_STAT, 32'h10);
        sendf(29'h500, 1'b0, 1'b0, 32'h55667788);
        rc(`CS_OFS_STAT, 32'h10, 32'h10);
        rc(`CS_OFS_NEWD, '1, 32'h1);
        sendf(29'h404, 1'b0, 1'b0, 32'h99aabbcc);
        wr(`CS_OFS_CMD, 32'h400);
        rc(`CS_OFS_FLAGS, 32'h7, 32'h3);
        rc(`CS_OFS_DLO, '1, 32'h99aabbcc);
        rc(`CS_OFS_NEWD, '1, 32'h0);
        sendf(29'h1a5, 1'b0, 1'b0, 32'h1);
        rc(`CS_OFS_NEWD, 32'h8, 32'h0);
        sendf(29'h1a5, 1'b1, 1'b0, 32'h2);
        rc(`CS_OFS_NEWD, 32'h8, 32'h8);
        $display("receive test done");
        eng_u.fail_cnt = 1;
        eng_u.slow     = 4;
        n = eng_u.sent_cnt;
        setobj(5'd1, 29'h0abcdef, '1, 14'h20c8, 32'h13579bdf, 1'b1);
        rc(`CS_OFS_TXP, '1, 32'h2);
        waitsent(n);
        chk({3'h0, eng_u.last_tx.id}, 32'h0abcdef);
        chk({31'h0, eng_u.last_tx.ext}, 32'h1);
        chk(eng_u.last_tx.data[31:0], 32'h13579bdf);
        rc(`CS_OFS_STAT, 32'h8, 32'h8);
        rc(`CS_OFS_TXP, '1, 32'h0);
        rc(`CS_OFS_IPND, 32'h2, 32'h2);
        wr(`CS_OFS_CTRL, 32'h0);
        rc(`CS_OFS_CTRL, 32'h1, 32'h0);
        chk({31'h0, o_auto_retransmit}, 32'h0);
        wr(`CS_OFS_STAT, 32'h8);
        eng_u.fail_cnt = 1;
        n = eng_u.sent_cnt;
        setobj(5'd1, 29'h0abcdef, '1, 14'h20c8, 32'h2468ace0, 1'b1);
        repeat (30) @(posedge i_core_clk);
        rc(`CS_OFS_TXP, '1, 32'h0);
        rc(`CS_OFS_STAT, 32'h8, 32'h0);
        chk(32'(eng_u.sent_cnt), 32'(n));
        $display("transmit test done");
        eng_u.slow = 0;
        n = eng_u.sent_cnt;
        sendf(29'h123, 1'b0, 1'b1, 32'h0);
        waitsent(n);
        chk({3'h0, eng_u.last_tx.id}, 32'h123);
        chk({31'h0, eng_u.last_tx.rtr}, 32'h0);
        chk(eng_u.last_tx.data[31:0], 32'hcafe0123);
        setobj(5'd4, 29'h77, '1, 14'h200b, 32'h0, 1'b0);
        setobj(5'd5, 29'h66, '1, 14'h2209, 32'h0, 1'b0);
        setobj(5'd6, 29'h66, '1, 14'h2009, 32'h0, 1'b0);
        sendf(29'h77, 1'b0, 1'b1, 32'h0);
        rc(`CS_OFS_IPND, 32'h10, 32'h10);
        wr(`CS_OFS_CMD, 32'h4);
        rc(`CS_OFS_FLAGS, 32'h7, 32'h5);
        sendf(29'h66, 1'b0, 1'b0, 32'h1);
        sendf(29'h66, 1'b0, 1'b0, 32'h2);
        rc(`CS_OFS_NEWD, 32'h60, 32'h60);
        $display("responder test done");
        wrap_up();
    end
endmodule // tb_top

`default_nettype wire
